// >>> src/dma_channel_address_count_regs.sv
// Per-channel DMA address, descriptor and count registers behind an APB slave
//
// How it works
// - Single mode: destination address is bank, high, low bytes, top to bottom.
// - Chained mode: destination bytes show the active buffer address; writes refused.
// - Single mode: source address is bank, high, low bytes, top to bottom.
// - Chained mode: top source byte is chain pointer base for descriptor addresses.
// - Buffer switch loads next descriptor address; chain pointer base untouched.
// - Current descriptor readable when enabled; low read captures high byte.
// - Chained transfer ends when current descriptor equals end descriptor.
// - End descriptor writable when enabled; low byte held until high byte write.
// - Only receive channels 0 and 2 have a receive buffer length.
// - Single mode ignores descriptor and buffer length registers.
// - Single mode count drops by one per byte, two per word.
// - Single transfer ends at count zero; start value zero moves 64 kbytes.
// - Chained count hits zero: switch buffer, reload from descriptor or buffer length.
// - Even channels receive into memory, odd channels transmit from memory.
// - Mode bit zero selects single transfer, one selects chained transfer.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
module dma_channel_address_count_regs #(
  parameter int NUM_CH = 4
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [dma_regs_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic                            pready_o,
  output logic [31:0]                     prdata_o,
  output logic                            pslverr_o,
  input  dma_regs_pkg::engine_req_t       eng_i,
  output dma_regs_pkg::chan_view_t [NUM_CH-1:0] view_o
);
  import dma_regs_pkg::*;

  // Receive and transmit channels come in pairs, so only 2 or 4 channels make sense
  if (NUM_CH < 2 || NUM_CH > NUM_CH_DOC || (NUM_CH % 2) != 0) begin : g_bad_num_ch
    $error("NUM_CH must be 2 or 4");
  end

  typedef struct packed {
    chan_t [NUM_CH-1:0] ch;
    logic               ready;
    logic               slverr;
    logic [31:0]        rdata;
  } state_t;

  state_t s;
  state_t next_s;

  // Address decode shared by read and write paths
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[IDX_LSB-1:0] == 2'b00) && (a[ADDR_W-1:CH_LSB+CH_W] == '0)
              && (int'(a[CH_LSB+CH_W-1:CH_LSB]) < NUM_CH);
  endfunction

  // Even channels face the receivers and write memory
  function automatic logic is_rx(input int i);
    is_rx = (i % 2) == 0;
  endfunction

  function automatic logic [7:0] read_byte(input chan_t c, input logic [3:0] idx, input logic rx);
    read_byte = 8'h00;
    unique case (idx)
      REG_DEST_LOW:  read_byte = c.dest[7:0];
      REG_DEST_HIGH: read_byte = c.dest[15:8];
      REG_DEST_BANK: read_byte = c.dest[23:16];
      REG_SRC_LOW:   read_byte = c.src[7:0];
      REG_SRC_HIGH:  read_byte = c.src[15:8];
      REG_SRC_BANK:  read_byte = c.src[23:16];
      REG_CDA_LOW:   read_byte = c.cda[7:0];
      REG_CDA_HIGH:  read_byte = c.cda_shadow;
      REG_EDA_LOW:   read_byte = c.eda[7:0];
      REG_EDA_HIGH:  read_byte = c.eda[15:8];
      REG_BFL_LOW:   read_byte = rx ? c.rx_buffer_length[7:0] : 8'h00;
      REG_BFL_HIGH:  read_byte = rx ? c.rx_buffer_length[15:8] : 8'h00;
      REG_CNT_LOW:   read_byte = c.count[7:0];
      REG_CNT_HIGH:  read_byte = c.count[15:8];
      REG_CTRL:      read_byte = {7'h00, c.chained};
      REG_STAT:      read_byte = {3'h0, c.switch_wait, c.done, c.st == CH_HALTED,
                                  c.st == CH_ENABLED, c.st == CH_INIT};
    endcase
  endfunction

  logic [IDX_W-1:0] idx;
  int unsigned      sel;
  assign idx = paddr_i[IDX_LSB+IDX_W-1:IDX_LSB];
  assign sel = int'(paddr_i[CH_LSB+CH_W-1:CH_LSB]);

  always_comb begin
    logic        wr;
    logic [7:0]  wd;
    logic [15:0] step;
    logic [15:0] left;
    wr     = 1'b0;
    wd     = 8'h00;
    step   = STEP_BYTE;
    left   = RESET_HALF;
    next_s = s;
    // Zero-wait slave: ready is raised in the access phase that follows every setup
    next_s.ready = psel_i && !penable_i;
    if (psel_i && !penable_i) begin
      next_s.slverr = !addr_ok(paddr_i);
      next_s.rdata  = 32'h0000_0000;
      if (addr_ok(paddr_i) && !pwrite_i) begin
        next_s.rdata = {24'h000000, read_byte(s.ch[sel], idx, is_rx(int'(sel)))};
        // High byte is frozen at the low-byte read so a 16-bit value reads coherently
        if (idx == REG_CDA_LOW) begin
          next_s.ch[sel].cda_shadow = s.ch[sel].cda[15:8];
        end
      end
    end
    wr = psel_i && penable_i && pwrite_i && s.ready && !s.slverr;
    wd = pwdata_i[7:0];
    for (int i = 0; i < NUM_CH; i++) begin
      next_s.ch[i].end_pulse = 1'b0;
      if (wr && sel == i) begin
        unique case (idx)
          REG_DEST_LOW:  if (!s.ch[i].chained) next_s.ch[i].dest[7:0]   = wd;
          REG_DEST_HIGH: if (!s.ch[i].chained) next_s.ch[i].dest[15:8]  = wd;
          REG_DEST_BANK: if (!s.ch[i].chained) next_s.ch[i].dest[23:16] = wd;
          REG_SRC_LOW:   next_s.ch[i].src[7:0]   = wd;
          REG_SRC_HIGH:  next_s.ch[i].src[15:8]  = wd;
          REG_SRC_BANK:  next_s.ch[i].src[23:16] = wd;
          REG_CDA_LOW:   next_s.ch[i].cda[7:0]   = wd;
          REG_CDA_HIGH:  next_s.ch[i].cda[15:8]  = wd;
          REG_EDA_LOW:   next_s.ch[i].eda_pend   = wd;
          REG_EDA_HIGH:  next_s.ch[i].eda = {wd, s.ch[i].eda_pend};
          REG_BFL_LOW:   if (is_rx(i)) next_s.ch[i].rx_buffer_length[7:0]  = wd;
          REG_BFL_HIGH:  if (is_rx(i)) next_s.ch[i].rx_buffer_length[15:8] = wd;
          REG_CNT_LOW:   if (!s.ch[i].chained) next_s.ch[i].count[7:0]  = wd;
          REG_CNT_HIGH:  if (!s.ch[i].chained) next_s.ch[i].count[15:8] = wd;
          REG_CTRL: begin
            // Mode is latched only while idle so a running transfer cannot change flavour
            if (s.ch[i].st == CH_INIT) begin
              next_s.ch[i].chained = wd[CTRL_MODE];
            end
            if (wd[CTRL_ABORT]) begin
              next_s.ch[i].st          = CH_INIT;
              next_s.ch[i].switch_wait = 1'b0;
            end else if (wd[CTRL_HALT] && s.ch[i].st == CH_ENABLED) begin
              next_s.ch[i].st = CH_HALTED;
            end else if (wd[CTRL_START] && s.ch[i].st != CH_ENABLED) begin
              next_s.ch[i].st = CH_ENABLED;
              // First descriptor is fetched before any data moves
              if (s.ch[i].st == CH_INIT && (s.ch[i].chained || wd[CTRL_MODE])) begin
                next_s.ch[i].switch_wait = 1'b1;
              end
            end
          end
          REG_STAT: if (wd[STAT_DONE]) next_s.ch[i].done = 1'b0;
        endcase
      end
      step = eng_i.word ? STEP_WORD : STEP_BYTE;
      left = s.ch[i].count - step;
      if (s.ch[i].st == CH_ENABLED && s.ch[i].chained && !s.ch[i].switch_wait
          && s.ch[i].cda == s.ch[i].eda) begin
        next_s.ch[i].st        = CH_INIT;
        next_s.ch[i].done      = 1'b1;
        next_s.ch[i].end_pulse = 1'b1;
      end else if (eng_i.moved && int'(eng_i.ch) == i && s.ch[i].st == CH_ENABLED
                   && !s.ch[i].switch_wait) begin
        next_s.ch[i].count = left;
        if (s.ch[i].chained || is_rx(i)) begin
          next_s.ch[i].dest = s.ch[i].dest + {8'h00, step};
        end else begin
          next_s.ch[i].src = s.ch[i].src + {8'h00, step};
        end
        if (left == RESET_HALF) begin
          if (s.ch[i].chained) begin
            next_s.ch[i].switch_wait = 1'b1;
          end else begin
            // A start count of zero wraps first, so the full 64 kbytes go out
            next_s.ch[i].st        = CH_INIT;
            next_s.ch[i].done      = 1'b1;
            next_s.ch[i].end_pulse = 1'b1;
          end
        end
      end else if (eng_i.switch_valid && int'(eng_i.ch) == i && s.ch[i].switch_wait
                   && s.ch[i].chained && s.ch[i].st == CH_ENABLED) begin
        // Only the low sixteen descriptor bits move; the base byte stays put
        next_s.ch[i].cda         = eng_i.next_desc;
        next_s.ch[i].dest        = eng_i.next_buf;
        next_s.ch[i].count       = is_rx(i) ? s.ch[i].rx_buffer_length : eng_i.desc_len;
        next_s.ch[i].switch_wait = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s.ready  <= 1'b0;
      s.slverr <= 1'b0;
      s.rdata  <= 32'h0000_0000;
      for (int i = 0; i < NUM_CH; i++) begin
        s.ch[i] <= '{st: CH_INIT, chained: 1'b0, dest: RESET_ADDR, src: RESET_ADDR,
                     cda: RESET_HALF, cda_shadow: RESET_BYTE, eda: RESET_HALF,
                     eda_pend: RESET_BYTE, rx_buffer_length: RESET_HALF, count: RESET_HALF,
                     done: 1'b0, switch_wait: 1'b0, end_pulse: 1'b0};
      end
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign pready_o  = s.ready;
  assign prdata_o  = s.rdata;
  assign pslverr_o = s.slverr;

  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_view
      assign view_o[g].enabled    = s.ch[g].st == CH_ENABLED;
      assign view_o[g].chained    = s.ch[g].chained;
      assign view_o[g].dest_addr  = s.ch[g].dest;
      assign view_o[g].src_addr   = s.ch[g].src;
      assign view_o[g].desc_addr  = {s.ch[g].src[23:16], s.ch[g].cda};
      assign view_o[g].count      = s.ch[g].count;
      assign view_o[g].switch_req = s.ch[g].switch_wait;
      assign view_o[g].end_pulse  = s.ch[g].end_pulse;
    end
  endgenerate
endmodule // dma_channel_address_count_regs

// >>> src/dma_regs_pkg.sv
// Register map, field layout and carrier types of the DMA address and count registers
package dma_regs_pkg;
  localparam int          NUM_CH_DOC    = 4;
  localparam int          ADDR_W        = 12;
  localparam int          IDX_LSB       = 2;
  localparam int          IDX_W         = 4;
  localparam int          CH_LSB        = 6;
  localparam int          CH_W          = 2;
  localparam logic [3:0]  REG_DEST_LOW  = 4'h0;
  localparam logic [3:0]  REG_DEST_HIGH = 4'h1;
  localparam logic [3:0]  REG_DEST_BANK = 4'h2;
  localparam logic [3:0]  REG_SRC_LOW   = 4'h3;
  localparam logic [3:0]  REG_SRC_HIGH  = 4'h4;
  localparam logic [3:0]  REG_SRC_BANK  = 4'h5;
  localparam logic [3:0]  REG_CDA_LOW   = 4'h6;
  localparam logic [3:0]  REG_CDA_HIGH  = 4'h7;
  localparam logic [3:0]  REG_EDA_LOW   = 4'h8;
  localparam logic [3:0]  REG_EDA_HIGH  = 4'h9;
  localparam logic [3:0]  REG_BFL_LOW   = 4'hA;
  localparam logic [3:0]  REG_BFL_HIGH  = 4'hB;
  localparam logic [3:0]  REG_CNT_LOW   = 4'hC;
  localparam logic [3:0]  REG_CNT_HIGH  = 4'hD;
  localparam logic [3:0]  REG_CTRL      = 4'hE;
  localparam logic [3:0]  REG_STAT      = 4'hF;
  localparam int          CTRL_MODE     = 0;
  localparam int          CTRL_START    = 1;
  localparam int          CTRL_HALT     = 2;
  localparam int          CTRL_ABORT    = 3;
  localparam int          STAT_INIT     = 0;
  localparam int          STAT_EN       = 1;
  localparam int          STAT_HALT     = 2;
  localparam int          STAT_DONE     = 3;
  localparam int          STAT_SWREQ    = 4;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [15:0] RESET_HALF    = 16'h0000;
  localparam logic [23:0] RESET_ADDR    = 24'h000000;
  localparam logic [15:0] STEP_BYTE     = 16'h0001;
  localparam logic [15:0] STEP_WORD     = 16'h0002;

  typedef enum logic [2:0] {
    CH_INIT    = 3'b001,
    CH_ENABLED = 3'b010,
    CH_HALTED  = 3'b100
  } chan_state_t;

  typedef struct packed {
    chan_state_t st;
    logic        chained;
    logic [23:0] dest;
    logic [23:0] src;
    logic [15:0] cda;
    logic [7:0]  cda_shadow;
    logic [15:0] eda;
    logic [7:0]  eda_pend;
    logic [15:0] rx_buffer_length;
    logic [15:0] count;
    logic        done;
    logic        switch_wait;
    logic        end_pulse;
  } chan_t;

  typedef struct packed {
    logic            moved;
    logic [CH_W-1:0] ch;
    logic            word;
    logic            switch_valid;
    logic [15:0]     next_desc;
    logic [23:0]     next_buf;
    logic [15:0]     desc_len;
  } engine_req_t;

  typedef struct packed {
    logic        enabled;
    logic        chained;
    logic [23:0] dest_addr;
    logic [23:0] src_addr;
    logic [23:0] desc_addr;
    logic [15:0] count;
    logic        switch_req;
    logic        end_pulse;
  } chan_view_t;
endpackage

// >>> verif/dma_regs_asserts.sv
// Concurrent checks on the ports of the DMA address and count register block
`timescale 1ns/1ps
module dma_regs_asserts
  import dma_regs_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic              pready_o,
  input wire logic [31:0]       prdata_o,
  input wire logic              pslverr_o,
  input engine_req_t            eng_i,
  input chan_view_t [NUM_CH-1:0] view_o
);
  // Engine and bus events that the design must act on; host writes are excluded while the engine moves
  wire acc0 = ce_i && eng_i.moved && eng_i.ch == 2'd0 && view_o[0].enabled && !view_o[0].switch_req;
  wire acc1 = ce_i && eng_i.moved && eng_i.ch == 2'd1 && view_o[1].enabled && !view_o[1].switch_req;
  wire sw1  = ce_i && eng_i.switch_valid && eng_i.ch == 2'd1 && view_o[1].switch_req;
  wire wr1  = ce_i && psel_i && penable_i && pready_o && pwrite_i && paddr_i[7:6] == 2'd1 &&
              view_o[1].chained && !eng_i.moved && !eng_i.switch_valid;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ready_after_setup_a: assert property (ce_i |=> pready_o == $past(psel_i && !penable_i))
    else $error("pready not exactly one cycle after setup");
  unmapped_err_a: assert property (ce_i && psel_i && !penable_i && paddr_i[11:8] != 4'h0 |=> pready_o && pslverr_o)
    else $error("unmapped access not refused");
  count_step_a: assert property (acc1 |=> view_o[1].count == $past(view_o[1].count) - ($past(eng_i.word) ? 16'h0002 : 16'h0001))
    else $error("count step wrong");
  single_end_a: assert property (
    acc1 && !view_o[1].chained && view_o[1].count == 16'h0001 && !eng_i.word |-> ##[1:3] view_o[1].end_pulse)
    else $error("single transfer did not end at zero");
  tx_src_step_a: assert property (acc1 && !view_o[1].chained
    |=> view_o[1].src_addr == $past(view_o[1].src_addr) + ($past(eng_i.word) ? 24'h000002 : 24'h000001))
    else $error("transmit source not advanced");
  rx_dest_step_a: assert property (acc0
    |=> view_o[0].dest_addr == $past(view_o[0].dest_addr) + ($past(eng_i.word) ? 24'h000002 : 24'h000001))
    else $error("receive destination not advanced");
  link_load_a: assert property (sw1
    |=> view_o[1].desc_addr == {$past(view_o[1].desc_addr[23:16]), $past(eng_i.next_desc)}
    && view_o[1].dest_addr == $past(eng_i.next_buf))
    else $error("buffer switch loaded wrong descriptor");
  tx_reload_a: assert property (sw1 |=> view_o[1].count == $past(eng_i.desc_len))
    else $error("count not reloaded from descriptor length");
  buf_write_block_a: assert property (wr1 && paddr_i[5:2] <= REG_DEST_BANK |=> $stable(view_o[1].dest_addr))
    else $error("buffer address written in chained mode");
  count_write_block_a: assert property (wr1 && paddr_i[5:3] == 3'b110 |=> $stable(view_o[1].count))
    else $error("count written in chained mode");

  end_seen_c: cover property (view_o[1].end_pulse);
  switch_seen_c: cover property (sw1);
  refused_seen_c: cover property (pslverr_o);
endmodule // dma_regs_asserts

// >>> verif/dma_engine_model.sv
// Behavioural transfer engine that feeds unit moves and buffer switches to the register block
`timescale 1ns/1ps
module dma_engine_model
  import dma_regs_pkg::*;
(
  input wire logic         clk_i,
  input chan_view_t [3:0]  view_i,
  output engine_req_t      eng_o
);
  initial eng_o = '0;
  // Each edge with moved high is one unit, so back-to-back units need no gap
  task automatic move(input logic [1:0] c, input logic w, input int n);
    repeat (n) begin
      @(posedge clk_i);
      eng_o.moved <= 1'b1;
      eng_o.ch <= c;
      eng_o.word <= w;
    end
    @(posedge clk_i);
    eng_o.moved <= 1'b0;
  endtask
  // Answers a pending switch after d idle cycles; released fields are inverted so stale values never pass
  task automatic link(input logic [1:0] c, input logic [15:0] nd, input logic [23:0] nb, input logic [15:0] len,
                      input int d);
    int k;
    k = 0;
    while (view_i[c].switch_req !== 1'b1 && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    repeat (d + 1) @(posedge clk_i);
    eng_o.switch_valid <= 1'b1;
    eng_o.ch <= c;
    eng_o.next_desc <= nd;
    eng_o.next_buf <= nb;
    eng_o.desc_len <= len;
    @(posedge clk_i);
    eng_o.switch_valid <= 1'b0;
    eng_o.next_desc <= ~nd;
    eng_o.next_buf <= ~nb;
    eng_o.desc_len <= ~len;
  endtask
endmodule // dma_engine_model

// >>> verif/dma_channel_address_count_regs_test.sv
// Self-checking bench for the DMA address and count register block
`timescale 1ns/1ps
module dma_channel_address_count_regs_test;
  import dma_regs_pkg::*;
  localparam int NUM_CH = 4;
  logic                    clk_i, rst_i, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0]       paddr;
  logic [31:0]             pwdata, prdata;
  logic [7:0]              rdat;
  logic [3:0]              hi;
  engine_req_t             eng;
  chan_view_t [NUM_CH-1:0] view;
  int                      mismatches, num_checks;

  dma_channel_address_count_regs #(.NUM_CH(NUM_CH)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .eng_i(eng), .view_o(view));
  dma_engine_model i_eng (.clk_i(clk_i), .view_i(view), .eng_o(eng));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [1:0] c, input logic [3:0] i, input logic [7:0] d);
    int   n;
    logic rdy;
    n   = 0;
    rdy = 1'b0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {hi, c, i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk_i);
    penable <= 1'b1;
    // Answer is judged on the settled value that the next rising edge samples
    do begin
      @(negedge clk_i);
      n++;
      rdy  = pready;
      rdat = prdata[7:0];
      err  = pslverr;
      @(posedge clk_i);
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Multi-byte values go low byte first, which the end descriptor pairing needs
  task automatic wrn(input logic [1:0] c, input logic [3:0] i, input logic [23:0] v, input int n);
    for (int k = 0; k < n; k++) apb(1'b1, c, i + 4'(k), v[8*k +: 8]);
  endtask
  task automatic wait_idle(input int c);
    int k;
    k = 0;
    while (view[c].enabled !== 1'b0 && k < 200) begin
      @(negedge clk_i);
      k++;
    end
    if (view[c].enabled !== 1'b0) mismatches++;
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    mismatches++;
    end_sim;
  end
  initial begin
    rst_i = 1'b1;
    ce = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, hi} = '0;
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wrn(1, REG_DEST_LOW, 24'h563412, 3);
    wrn(1, REG_SRC_LOW, 24'h030201, 3);
    wrn(1, REG_CNT_LOW, 24'h000003, 2);
    @(negedge clk_i);
    chk(view[1].dest_addr, 24'h563412);
    chk(view[1].src_addr, 24'h030201);
    apb(1'b1, 1, REG_CTRL, 8'h02);
    i_eng.move(1, 1'b1, 1);
    i_eng.move(1, 1'b0, 1);
    wait_idle(1);
    chk(view[1].src_addr, 24'h030204);
    chk(view[1].count, 16'h0000);
    apb(1'b0, 1, REG_STAT, 8'h00);
    chk(rdat[3], 1'b1);
    apb(1'b1, 1, REG_STAT, 8'h08);
    $display("test single_block done");
    wrn(1, REG_SRC_BANK, 24'h00007A, 1);
    wrn(1, REG_CDA_LOW, 24'h000100, 2);
    wrn(1, REG_EDA_LOW, 24'h000300, 2);
    apb(1'b1, 1, REG_CTRL, 8'h03);
    i_eng.link(1, 16'h0100, 24'hABCDEF, 16'h0002, 3);
    apb(1'b1, 1, REG_DEST_LOW, 8'h55);
    apb(1'b1, 1, REG_CNT_LOW, 8'h77);
    @(negedge clk_i);
    chk(view[1].desc_addr, 24'h7A0100);
    chk(view[1].dest_addr, 24'hABCDEF);
    chk(view[1].count, 16'h0002);
    apb(1'b0, 1, REG_CTRL, 8'h00);
    chk(rdat[0], 1'b1);
    apb(1'b0, 1, REG_CDA_LOW, 8'h00);
    chk(rdat, 8'h00);
    wrn(1, REG_EDA_LOW, 24'h000220, 2);
    i_eng.move(1, 1'b0, 2);
    i_eng.link(1, 16'h0220, 24'h002000, 16'h0009, 0);
    wait_idle(1);
    chk(view[1].desc_addr, 24'h7A0220);
    apb(1'b0, 1, REG_CDA_HIGH, 8'h00);
    chk(rdat, 8'h01);
    apb(1'b1, 1, REG_EDA_LOW, 8'h44);
    apb(1'b0, 1, REG_EDA_LOW, 8'h00);
    chk(rdat, 8'h20);
    $display("test chained_block done");
    wrn(0, REG_BFL_LOW, 24'h000055, 1);
    apb(1'b0, 0, REG_BFL_LOW, 8'h00);
    chk(rdat, 8'h55);
    wrn(1, REG_BFL_LOW, 24'h000055, 1);
    apb(1'b0, 1, REG_BFL_LOW, 8'h00);
    chk(rdat, 8'h00);
    apb(1'b1, 0, REG_CTRL, 8'h02);
    i_eng.move(0, 1'b0, 1);
    @(negedge clk_i);
    chk(view[0].count, 16'hFFFF);
    chk(view[0].dest_addr, 24'h000001);
    chk(view[0].enabled, 1'b1);
    @(posedge clk_i);
    ce <= 1'b0;
    i_eng.move(0, 1'b0, 2);
    ce <= 1'b1;
    @(negedge clk_i);
    chk(view[0].count, 16'hFFFF);
    chk(view[0].dest_addr, 24'h000001);
    hi = 4'h1;
    apb(1'b0, 0, REG_STAT, 8'h00);
    hi = 4'h0;
    chk(err, 1'b1);
    $display("test receive_wrap done");
    end_sim;
  end
endmodule // dma_channel_address_count_regs_test

bind dma_channel_address_count_regs dma_regs_asserts #(.NUM_CH(NUM_CH)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .eng_i(eng_i),
  .view_o(view_o));
